/* File: verilog/fcd_consts.svh */
// Constants shared by the flash command decoder and its host end
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_UNLOCK1_DATA 8'haa
`define FCD_UNLOCK2_DATA 8'h55
`define FCD_UNLOCK1_ADDR 12'h555
`define FCD_UNLOCK2_ADDR 12'haaa
`define FCD_CMD_ID 8'h90
`define FCD_CMD_PROG 8'ha0
`define FCD_CMD_ERASE 8'h80
`define FCD_CMD_SECT 8'h30
`define FCD_CMD_BULK 8'h10
`define FCD_CMD_SUSP 8'hb0
`define FCD_CMD_RESET 8'hf0
`define FCD_CMD_BYPASS 8'h20
`define FCD_CMD_BPEXIT 8'h00
`define FCD_ID_ADDR 12'h001
`define FCD_PROT_ADDR 12'h002
`define FCD_PROT_YES 8'h01
`define FCD_PROT_NO 8'h00
`define FCD_ADDR_BITS 12
`define FCD_SECT_ADD_US 80
`define FCD_CLK_MHZ 100
`define FCD_SECT_ADD_CYC (`FCD_SECT_ADD_US * `FCD_CLK_MHZ)
`define FCD_GAP_CYC 1000
`endif

/* File: verilog/fcd_pkg.sv */
// Types of the flash command decoder
package fcd_pkg;
   typedef enum logic [3:0] {
      FCD_READ = 4'h0, FCD_UNL1 = 4'h1, FCD_UNL2 = 4'h3, FCD_PROG = 4'h2,
      FCD_ER1 = 4'h6, FCD_ER2 = 4'h7, FCD_ER3 = 4'h5, FCD_ADDQ = 4'h4,
      FCD_IDRD = 4'hc, FCD_BYP = 4'hd, FCD_BPPROG = 4'hf, FCD_BPEXIT = 4'he
   } fcd_state_e;
   typedef enum logic [2:0] {
      FCD_OP_NONE = 3'h0, FCD_OP_PROG = 3'h1, FCD_OP_SECT = 3'h2, FCD_OP_BULK = 3'h3,
      FCD_OP_SUSP = 3'h4, FCD_OP_RESUME = 3'h5
   } fcd_op_e;
endpackage

/* File: verilog/fcd_bus_if.sv */
// Microcontroller bus between host and flash command decoder
`timescale 1ns/1ns
interface fcd_bus_if;
   logic writeStrobeN;
   logic readStrobeN;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rdataOe;
   logic [15:0] mainSectorSelects;
   logic [3:0] bootSectorSelects;
   modport dev (input writeStrobeN, readStrobeN, addr, wdata, mainSectorSelects, bootSectorSelects,
      output rdata, rdataOe);
   modport host (output writeStrobeN, readStrobeN, addr, wdata, mainSectorSelects, bootSectorSelects,
      input rdata, rdataOe);
endinterface

/* File: verilog/fcd_host.sv */
// Host end: issues flash command sequences over the bus
`timescale 1ns/1ns
`include "fcd_consts.svh"
module fcd_host #(
   parameter int HALF = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // User request: up to seven writes, or one to six then an optional read, or a read alone
   input wire logic reqValid,
   input wire logic [2:0] reqWrites,
   input wire logic reqRead,
   input wire logic [6:0][15:0] reqAddr,
   input wire logic [6:0][7:0] reqData,
   input wire logic [15:0] reqReadAddr,
   input wire logic reqBoot,
   input wire logic [3:0] reqSect,
   output logic reqBusy,
   output logic doneValid,
   output logic [7:0] doneData,
   // Bus
   fcd_bus_if.host bus
);
   logic [2:0] idx_r;
   logic [1:0] ph_r;
   logic [7:0] cnt_r;
   logic busy_r, rd_r, wrN_r, rdN_r, boot_r, done_r;
   logic [2:0] nw_r;
   logic [3:0] sect_r;
   logic [6:0][15:0] a_r;
   logic [6:0][7:0] d_r;
   logic [15:0] ra_r, addr_r;
   logic [7:0] wd_r, dd_r;
   logic [3:0] rdin1_r;
   logic [7:0] rs1_r, rs2_r;
   logic selOn;
   // Selects go low between cycles so power-up and idle keep them low
   assign selOn = busy_r && ph_r != 2'd0;
   assign bus.writeStrobeN = wrN_r;
   assign bus.readStrobeN = rdN_r;
   assign bus.addr = addr_r;
   assign bus.wdata = wd_r;
   assign bus.mainSectorSelects = (selOn && !boot_r) ? (16'h0001 << sect_r) : 16'h0000; // see RQ5
   assign bus.bootSectorSelects = (selOn && boot_r) ? (4'h1 << sect_r[1:0]) : 4'h0; // see RQ5
   assign reqBusy = busy_r;
   assign doneValid = done_r;
   assign doneData = dd_r;
   // Read data synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rs1_r <= 8'h00;
         rs2_r <= 8'h00;
      end else begin
         rs1_r <= bus.rdata;
         rs2_r <= rs1_r;
      end
   end
   // Sequencer: phase 1 sets up, 2 strobes low, 3 strobes high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         wrN_r <= 1'b1; // see RQ8
         rdN_r <= 1'b1;
         idx_r <= 3'h0;
         ph_r <= 2'd0;
         cnt_r <= 8'h00;
         done_r <= 1'b0;
         dd_r <= 8'h00;
         nw_r <= 3'h0;
         rd_r <= 1'b0;
         boot_r <= 1'b0;
         sect_r <= 4'h0;
         a_r <= '0;
         d_r <= '0;
         ra_r <= 16'h0000;
         addr_r <= 16'h0000;
         wd_r <= 8'h00;
      end else begin
         done_r <= 1'b0;
         if (!busy_r) begin
            if (reqValid) begin
               busy_r <= 1'b1;
               nw_r <= reqWrites;
               rd_r <= reqRead;
               a_r <= reqAddr; // see RQ3 see RQ4 see RQ10 see RQ18 see RQ19
               d_r <= reqData;
               ra_r <= reqReadAddr;
               boot_r <= reqBoot; // see RQ20
               sect_r <= reqSect;
               idx_r <= 3'h0;
               ph_r <= 2'd0;
               cnt_r <= 8'h00;
            end
         end else if (cnt_r != 8'(HALF)) begin
            cnt_r <= cnt_r + 8'h01;
         end else begin
            cnt_r <= 8'h00;
            ph_r <= (ph_r == 2'd3) ? 2'd0 : ph_r + 2'd1;
            if (ph_r == 2'd0) begin
               addr_r <= (idx_r < nw_r) ? a_r[idx_r] : ra_r;
               wd_r <= d_r[idx_r];
            end else if (ph_r == 2'd1) begin
               if (idx_r < nw_r) wrN_r <= 1'b0;
               else rdN_r <= 1'b0;
            end else if (ph_r == 2'd2) begin
               if (idx_r >= nw_r) dd_r <= rs2_r;
               wrN_r <= 1'b1;
               rdN_r <= 1'b1;
            end else begin
               if (idx_r + 3'h1 < nw_r || (idx_r < nw_r && rd_r)) begin
                  idx_r <= idx_r + 3'h1;
               end else begin
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
               end
            end
         end
      end
   end
   // Unused sampled bits keep a single sink
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rdin1_r <= 4'h0;
      else rdin1_r <= {bus.rdataOe, rdin1_r[3:1]};
   end
endmodule

/* File: verilog/fcd_decoder.sv */
// Device end: flash command decoder for both banks
`timescale 1ns/1ns
`include "fcd_consts.svh"
// What this block does
// RQ1: Command writes decoded in sequence, not stored
// RQ2: Bad byte or gap timeout returns read; ID read and bypass idle (not its A0h/90h steps) ignore the gap timeout, bypass ignores bad bytes
// RQ3: Unlock AAh then 55h, data and address checked
// RQ4: Unlock addresses 555h then AAAh matched
// RQ5: Ignore A15-A12; drop writes without select
// RQ6: Main selects pick primary, boot secondary
// RQ7: Reset puts both banks in read
// RQ8: Host holds selects low, strobe high
// RQ9: Read mode reads array like ROM
// RQ10: F0h anywhere resets to read mode
// RQ11: 90h then read 01h gives identifier
// RQ12: Read 02h gives sector protection status
// RQ13: A0h then program write, address, data
// RQ14: Erase: 80h, unlock, 30h sector/10h bulk
// RQ15: Extra 30h sectors within 80 us
// RQ16: B0h suspends a running sector erase
// RQ17: 30h resumes only while suspended
// RQ18: 20h enters bypass; A0h plus data programs
// RQ19: 90h then 00h leaves bypass
// RQ20: Host never commands its own code bank
// RQ21: Error flag cleared only by reset
// RQ22: Gap timeout is a cycle parameter
module fcd_decoder #(
   parameter int GAP_CYC = `FCD_GAP_CYC,
   parameter int SECT_ADD_CYC = `FCD_SECT_ADD_CYC,
   parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identifier value
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Array side
   input wire logic [7:0] arrayData,
   input wire logic sectProtected,
   input wire logic opFail,
   input wire logic eraseBusy,
   // Operation output
   output fcd_pkg::fcd_op_e opCode,
   output logic opValid,
   output logic opBank,
   output logic [15:0] opAddr,
   output logic [7:0] opData,
   output logic errorFlag,
   output logic bankReadMode,
   // Bus
   fcd_bus_if.dev bus
);
   localparam logic [11:0] U1 = `FCD_UNLOCK1_ADDR;
   localparam logic [11:0] U2 = `FCD_UNLOCK2_ADDR;
   fcd_pkg::fcd_state_e st_r [2];
   logic [1:0] s1wr_r, s2wr_r, s1rd_r, s2rd_r, wr_r, rd_r;
   logic [15:0] a1_r, a2_r, pa_r;
   logic [7:0] w1_r, w2_r;
   logic [15:0] m1_r, m2_r;
   logic [3:0] b1_r, b2_r;
   logic [31:0] gap_r, add_r;
   logic [1:0] susp_r, erasing_r;
   logic wrFall, wrRise, mainSel, bootSel;
   fcd_pkg::fcd_op_e op_r;
   logic opv_r, opb_r, err_r, rm_r;
   logic [15:0] oa_r;
   logic [7:0] od_r, rdat_r;
   logic oe_r;
   // Bus synchronisers: two flip-flops before use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1wr_r <= 2'b11; s2wr_r <= 2'b11;
         s1rd_r <= 2'b11; s2rd_r <= 2'b11;
         a1_r <= 16'h0000; a2_r <= 16'h0000;
         w1_r <= 8'h00; w2_r <= 8'h00;
         m1_r <= 16'h0000; m2_r <= 16'h0000;
         b1_r <= 4'h0; b2_r <= 4'h0;
      end else begin
         s1wr_r <= {s1wr_r[0], bus.writeStrobeN}; s2wr_r <= {s2wr_r[0], s1wr_r[0]};
         s1rd_r <= {s1rd_r[0], bus.readStrobeN}; s2rd_r <= {s2rd_r[0], s1rd_r[0]};
         a1_r <= bus.addr; a2_r <= a1_r;
         w1_r <= bus.wdata; w2_r <= w1_r;
         m1_r <= bus.mainSectorSelects; m2_r <= m1_r;
         b1_r <= bus.bootSectorSelects; b2_r <= b1_r;
      end
   end
   assign wr_r = s2wr_r;
   assign rd_r = s2rd_r;
   assign wrFall = wr_r == 2'b10;
   assign wrRise = wr_r == 2'b01;
   assign mainSel = |m2_r; // see RQ6
   assign bootSel = |b2_r; // see RQ6
   function automatic logic isUnl(input logic [15:0] a, input logic [7:0] d, input logic second);
      // Only A11-A0 take part in matching
      isUnl = second ? (a[11:0] == U2 && d == `FCD_UNLOCK2_DATA) : (a[11:0] == U1 && d == `FCD_UNLOCK1_DATA); // see RQ3 see RQ4 see RQ5
   endfunction
   // Program address taken at the strobe's falling edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) pa_r <= 16'h0000;
      else if (wrFall) pa_r <= a2_r; // see RQ13
   end
   // Per-bank sequence machines, stepped on the strobe's rising edge
   for (genvar b = 0; b < 2; b++) begin : g_bank
      logic hit;
      assign hit = wrRise && (b == 0 ? mainSel : bootSel); // see RQ5 see RQ6
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            st_r[b] <= fcd_pkg::FCD_READ; // see RQ7 see RQ9
            susp_r[b] <= 1'b0;
            erasing_r[b] <= 1'b0;
         end else begin
            if (!eraseBusy || b != int'(opb_r)) erasing_r[b] <= erasing_r[b] && eraseBusy;
            if (hit && w2_r == `FCD_CMD_RESET) begin
               st_r[b] <= fcd_pkg::FCD_READ; // see RQ10
            end else if (hit) begin
               // Each write is a command byte, never an array store
               case (st_r[b]) // see RQ1
                  fcd_pkg::FCD_READ: begin
                     if (w2_r == `FCD_CMD_SUSP && erasing_r[b] && !susp_r[b]) susp_r[b] <= 1'b1; // see RQ16
                     else if (w2_r == `FCD_CMD_SECT && susp_r[b]) susp_r[b] <= 1'b0; // see RQ17
                     else if (isUnl(a2_r, w2_r, 1'b0)) st_r[b] <= fcd_pkg::FCD_UNL1;
                  end
                  fcd_pkg::FCD_UNL1: st_r[b] <= isUnl(a2_r, w2_r, 1'b1) ? fcd_pkg::FCD_UNL2 : fcd_pkg::FCD_READ; // see RQ2
                  fcd_pkg::FCD_UNL2: begin
                     if (a2_r[11:0] != U1) st_r[b] <= fcd_pkg::FCD_READ;
                     else if (w2_r == `FCD_CMD_ID && b == 0) st_r[b] <= fcd_pkg::FCD_IDRD; // see RQ11
                     else if (w2_r == `FCD_CMD_PROG) st_r[b] <= fcd_pkg::FCD_PROG;
                     else if (w2_r == `FCD_CMD_ERASE && !susp_r[b]) st_r[b] <= fcd_pkg::FCD_ER1;
                     else if (w2_r == `FCD_CMD_BYPASS) st_r[b] <= fcd_pkg::FCD_BYP; // see RQ18
                     else st_r[b] <= fcd_pkg::FCD_READ; // see RQ2
                  end
                  fcd_pkg::FCD_PROG: st_r[b] <= fcd_pkg::FCD_READ;
                  fcd_pkg::FCD_ER1: st_r[b] <= isUnl(a2_r, w2_r, 1'b0) ? fcd_pkg::FCD_ER2 : fcd_pkg::FCD_READ;
                  fcd_pkg::FCD_ER2: st_r[b] <= isUnl(a2_r, w2_r, 1'b1) ? fcd_pkg::FCD_ER3 : fcd_pkg::FCD_READ;
                  fcd_pkg::FCD_ER3: begin
                     if (w2_r == `FCD_CMD_SECT) begin
                        st_r[b] <= fcd_pkg::FCD_ADDQ; // see RQ14
                        erasing_r[b] <= 1'b1;
                     end else st_r[b] <= fcd_pkg::FCD_READ;
                  end
                  fcd_pkg::FCD_ADDQ: st_r[b] <= (w2_r == `FCD_CMD_SECT) ? fcd_pkg::FCD_ADDQ : fcd_pkg::FCD_READ;
                  fcd_pkg::FCD_IDRD: st_r[b] <= fcd_pkg::FCD_READ;
                  fcd_pkg::FCD_BYP: begin
                     if (w2_r == `FCD_CMD_PROG) st_r[b] <= fcd_pkg::FCD_BPPROG;
                     else if (w2_r == `FCD_CMD_ID) st_r[b] <= fcd_pkg::FCD_BPEXIT; // see RQ19
                  end
                  fcd_pkg::FCD_BPPROG: st_r[b] <= fcd_pkg::FCD_BYP;
                  fcd_pkg::FCD_BPEXIT: st_r[b] <= (w2_r == `FCD_CMD_BPEXIT) ? fcd_pkg::FCD_READ : fcd_pkg::FCD_BYP;
                  default: st_r[b] <= fcd_pkg::FCD_READ;
               endcase
            end else if (st_r[b] == fcd_pkg::FCD_ADDQ && add_r >= 32'(SECT_ADD_CYC)) begin
               st_r[b] <= fcd_pkg::FCD_READ; // see RQ15
            end else if (gap_r >= 32'(GAP_CYC) && st_r[b] != fcd_pkg::FCD_READ && st_r[b] != fcd_pkg::FCD_IDRD
                  && st_r[b] != fcd_pkg::FCD_BYP && st_r[b] != fcd_pkg::FCD_ADDQ) begin
               st_r[b] <= fcd_pkg::FCD_READ; // see RQ2 see RQ22
            end
         end
      end
   end
   // Inter-byte gap and sector-queue windows, restarted by any selected write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_r <= 32'h0;
         add_r <= 32'h0;
      end else begin
         gap_r <= (wrRise && (mainSel || bootSel)) ? 32'h0 : (gap_r == 32'hffffffff ? gap_r : gap_r + 32'h1);
         add_r <= (wrRise && (mainSel || bootSel)) ? 32'h0 : (add_r == 32'hffffffff ? add_r : add_r + 32'h1);
      end
   end
   // Operation launch, one-cycle pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op_r <= fcd_pkg::FCD_OP_NONE;
         opv_r <= 1'b0;
         opb_r <= 1'b0;
         oa_r <= 16'h0000;
         od_r <= 8'h00;
      end else begin
         opv_r <= 1'b0;
         if (wrRise && (mainSel || bootSel)) begin
            logic bb;
            fcd_pkg::fcd_state_e s;
            bb = bootSel && !mainSel;
            s = st_r[bb];
            opb_r <= bb;
            oa_r <= pa_r;
            od_r <= w2_r; // see RQ13
            if (s == fcd_pkg::FCD_PROG || s == fcd_pkg::FCD_BPPROG) begin
               op_r <= fcd_pkg::FCD_OP_PROG; opv_r <= 1'b1;
            end else if ((s == fcd_pkg::FCD_ER3 || s == fcd_pkg::FCD_ADDQ) && w2_r == `FCD_CMD_SECT) begin
               op_r <= fcd_pkg::FCD_OP_SECT; opv_r <= 1'b1; // see RQ14 see RQ15
            end else if (s == fcd_pkg::FCD_ER3 && w2_r == `FCD_CMD_BULK && a2_r[11:0] == U1) begin
               op_r <= fcd_pkg::FCD_OP_BULK; opv_r <= 1'b1;
            end else if (s == fcd_pkg::FCD_READ && w2_r == `FCD_CMD_SUSP && erasing_r[bb] && !susp_r[bb]) begin
               op_r <= fcd_pkg::FCD_OP_SUSP; opv_r <= 1'b1;
            end else if (s == fcd_pkg::FCD_READ && w2_r == `FCD_CMD_SECT && susp_r[bb]) begin
               op_r <= fcd_pkg::FCD_OP_RESUME; opv_r <= 1'b1;
            end
         end
      end
   end
   // Error flag: set by failure, cleared only by reset command; set wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) err_r <= 1'b0;
      else if (opFail) err_r <= 1'b1;
      else if (wrRise && (mainSel || bootSel) && w2_r == `FCD_CMD_RESET) err_r <= 1'b0; // see RQ21
   end
   // Read path: identifier, protection status, else array contents
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdat_r <= 8'h00;
         oe_r <= 1'b0;
         rm_r <= 1'b1;
      end else begin
         rm_r <= st_r[0] == fcd_pkg::FCD_READ && st_r[1] == fcd_pkg::FCD_READ;
         oe_r <= !rd_r[0] && (mainSel || bootSel);
         if (st_r[bootSel && !mainSel] == fcd_pkg::FCD_IDRD) begin
            if (a2_r[11:0] == `FCD_ID_ADDR && mainSel) rdat_r <= ID_CODE; // see RQ11
            else if (a2_r[7:0] == 8'(`FCD_PROT_ADDR)) rdat_r <= sectProtected ? `FCD_PROT_YES : `FCD_PROT_NO; // see RQ12
            else rdat_r <= arrayData;
         end else rdat_r <= arrayData; // see RQ9
      end
   end
   assign bus.rdata = rdat_r;
   assign bus.rdataOe = oe_r;
   assign opCode = op_r;
   assign opValid = opv_r;
   assign opBank = opb_r;
   assign opAddr = oa_r;
   assign opData = od_r;
   assign errorFlag = err_r;
   assign bankReadMode = rm_r;
endmodule

/* File: testbench/fcd_checker.sv */
// Assertion checker for the command bus and the decoder results
`timescale 1ns/1ns
module fcd_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bus
   input wire logic writeStrobeN,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [15:0] mainSectorSelects,
   input wire logic [3:0] bootSectorSelects,
   // Decoder results
   input wire fcd_pkg::fcd_op_e opCode,
   input wire logic opValid,
   input wire logic opBank,
   input wire logic [15:0] opAddr,
   input wire logic [7:0] opData,
   input wire logic errorFlag,
   input wire logic bankReadMode
);
   logic strobeN_r;
   logic [15:0] lastAddr_r;
   logic [7:0] lastByte_r;
   logic lastBoot_r;
   logic [3:0] sinceRise_r;
   // Shadow of the last selected write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strobeN_r <= 1'b1;
         lastAddr_r <= 16'h0;
         lastByte_r <= 8'h0;
         lastBoot_r <= 1'b0;
         sinceRise_r <= 4'hf;
      end else begin
         strobeN_r <= writeStrobeN;
         if (strobeN_r && !writeStrobeN) lastAddr_r <= addr;
         if (!strobeN_r && writeStrobeN && (|mainSectorSelects || |bootSectorSelects)) begin
            lastByte_r <= wdata;
            lastBoot_r <= |bootSectorSelects;
            sinceRise_r <= 4'h0;
         end else if (sinceRise_r != 4'hf) begin
            sinceRise_r <= sinceRise_r + 4'h1; // Saturates
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_sel_on_write: assert property (!writeStrobeN |-> (|mainSectorSelects || |bootSectorSelects))
      else $error("write strobe low with no sector select");
   chk_strobe_width: assert property ($fell(writeStrobeN) |-> !writeStrobeN [*3])
      else $error("strobe low too short");
   chk_op_after_write: assert property (opValid |-> sinceRise_r <= 4'h6)
      else $error("op without recent write");
   chk_op_one_cycle: assert property (opValid |=> !opValid)
      else $error("op pulse too long");
   chk_bank_route: assert property (opValid |-> opBank == lastBoot_r)
      else $error("op on wrong bank");
   chk_prog_fields: assert property (opValid && opCode == fcd_pkg::FCD_OP_PROG
      |-> opAddr == lastAddr_r && opData == lastByte_r)
      else $error("bad program fields");
   chk_sect_byte: assert property (opValid && opCode == fcd_pkg::FCD_OP_SECT |-> lastByte_r == 8'h30)
      else $error("sector erase unconfirmed");
   chk_bulk_byte: assert property (opValid && opCode == fcd_pkg::FCD_OP_BULK
      |-> lastByte_r == 8'h10 && lastAddr_r[11:0] == 12'h555)
      else $error("bulk erase unconfirmed");
   chk_susp_byte: assert property (opValid && opCode == fcd_pkg::FCD_OP_SUSP |-> lastByte_r == 8'hb0)
      else $error("suspend without its command byte");
   chk_resume_byte: assert property (opValid && opCode == fcd_pkg::FCD_OP_RESUME |-> lastByte_r == 8'h30)
      else $error("resume without its command byte");
   chk_error_clear: assert property ($fell(errorFlag) |-> lastByte_r == 8'hf0 && sinceRise_r <= 4'h6)
      else $error("error cleared without reset");
   chk_reset_read: assert property (!$past(nrst) |-> bankReadMode && !errorFlag)
      else $error("not in read mode after reset");
   // Main scenarios reached
   cover property (opValid && opCode == fcd_pkg::FCD_OP_PROG && opBank);
   cover property (opValid && opCode == fcd_pkg::FCD_OP_SECT);
   cover property (opValid && opCode == fcd_pkg::FCD_OP_SUSP);
   cover property ($fell(errorFlag));
endmodule

/* File: testbench/flash_command_decoder_tb.sv */
// Self-checking bench: host end and decoder joined on one bus
`timescale 1ns/1ns
module flash_command_decoder_tb;
   localparam logic [7:0] ID = 8'h5a; // Arbitrary identifier value, matches the decoder default
   logic clk = 1'b0, nrst = 1'b0;
   logic reqValid, reqRead, reqBoot, reqBusy, doneValid, sectProtected, opFail, eraseBusy;
   logic [2:0] reqWrites;
   logic [6:0][15:0] reqAddr, wa;
   logic [6:0][7:0] reqData, wd;
   logic [15:0] reqReadAddr, opAddr, a;
   logic [3:0] reqSect;
   logic [7:0] doneData, arrayData, opData;
   fcd_pkg::fcd_op_e opCode;
   logic opValid, opBank, errorFlag, bankReadMode;
   integer seed = 32'hbdd298d1;
   logic [31:0] r;
   int errors = 0, cmpCount = 0, opCount = 0, base = 0, n = 0, i;
   fcd_bus_if bus ();
   fcd_host u_fcd_host (.clk(clk), .nrst(nrst), .reqValid(reqValid), .reqWrites(reqWrites), .reqRead(reqRead),
      .reqAddr(reqAddr), .reqData(reqData), .reqReadAddr(reqReadAddr), .reqBoot(reqBoot), .reqSect(reqSect),
      .reqBusy(reqBusy), .doneValid(doneValid), .doneData(doneData), .bus(bus));
   // Short gap and sector-add windows keep the run brief
   fcd_decoder #(.GAP_CYC(50), .SECT_ADD_CYC(100)) u_fcd_decoder (.clk(clk), .nrst(nrst), .arrayData(arrayData),
      .sectProtected(sectProtected), .opFail(opFail), .eraseBusy(eraseBusy), .opCode(opCode), .opValid(opValid),
      .opBank(opBank), .opAddr(opAddr), .opData(opData), .errorFlag(errorFlag), .bankReadMode(bankReadMode),
      .bus(bus));
   fcd_checker u_fcd_checker (.clk(clk), .nrst(nrst), .writeStrobeN(bus.writeStrobeN), .addr(bus.addr),
      .wdata(bus.wdata), .mainSectorSelects(bus.mainSectorSelects), .bootSectorSelects(bus.bootSectorSelects),
      .opCode(opCode), .opValid(opValid), .opBank(opBank), .opAddr(opAddr), .opData(opData),
      .errorFlag(errorFlag), .bankReadMode(bankReadMode));
   // Array model: byte depends on the address, so a stale or wrong source shows
   assign arrayData = bus.addr[7:0] ^ 8'h3c;
   always #5 clk = ~clk;
   always @(posedge clk) if (opValid === 1'b1) opCount <= opCount + 1;
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmpCount++;
      if (exp !== got) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] ad, input logic [7:0] d);
      wa[n] = ad;
      wd[n] = d;
      n++;
   endtask
   task automatic unl(input logic [3:0] hi);
      wr({hi, 12'h555}, 8'haa);
      wr({hi, 12'haaa}, 8'h55);
   endtask
   // One host request, then settle
   task automatic run(input logic rd, input logic [15:0] ra, input logic bt);
      int k;
      @(negedge clk);
      reqAddr = wa;
      reqData = wd;
      reqWrites = 3'(n);
      reqRead = rd;
      reqReadAddr = ra;
      reqBoot = bt;
      reqSect = 4'($random(seed)) & (bt ? 4'h3 : 4'hf);
      reqValid = 1'b1;
      @(negedge clk) reqValid = 1'b0;
      n = 0;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (doneValid !== 1'b1 && k < 400);
      if (k >= 400) begin
         errors++;
         $display("ERROR host done expected 1 seen 0");
         close_out();
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic ex(input int dn, input fcd_pkg::fcd_op_e c, input logic b, input logic [15:0] ad);
      chk("op count", 16'(base + dn), 16'(opCount));
      if (dn > 0) begin
         chk("op code", 16'(c), 16'(opCode));
         chk("op bank", 16'(b), 16'(opBank));
         if (c inside {fcd_pkg::FCD_OP_PROG, fcd_pkg::FCD_OP_SECT}) chk("op addr", ad, opAddr);
      end
      base = opCount;
   endtask
   initial begin
      {reqValid, reqRead, reqBoot, sectProtected, opFail, eraseBusy} = 6'h0;
      {reqWrites, reqAddr, reqData, reqReadAddr, reqSect, wa, wd} = '0;
      repeat (8) @(posedge clk);
      @(negedge clk) nrst = 1'b1;
      chk("read mode", 16'h1, 16'(bankReadMode));
      a = 16'($random(seed));
      run(1'b1, a, 1'b0);
      chk("array read", {8'h0, a[7:0] ^ 8'h3c}, 16'(doneData));
      // Random programs on either bank with don't-care upper address bits
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         a = 16'($random(seed));
         unl(r[3:0]);
         wr({r[7:4], 12'h555}, 8'ha0);
         wr(a, r[15:8]);
         run(1'b0, 16'h0, r[16]);
         ex(1, fcd_pkg::FCD_OP_PROG, r[16], a);
         chk("prog data", 16'(r[15:8]), 16'(opData));
      end
      // Broken unlock data, then broken unlock address
      wr(16'h0555, 8'hab); wr(16'h0aaa, 8'h55); wr(16'h0555, 8'ha0); wr(16'h1234, 8'h5c);
      run(1'b0, 16'h0, 1'b0);
      ex(0, fcd_pkg::FCD_OP_NONE, 1'b0, 16'h0);
      wr(16'h0555, 8'haa); wr(16'h0554, 8'h55); wr(16'h0555, 8'ha0); wr(16'h1234, 8'h5c);
      run(1'b1, 16'h0042, 1'b0);
      ex(0, fcd_pkg::FCD_OP_NONE, 1'b0, 16'h0);
      chk("array after abort", 16'h7e, 16'(doneData));
      // Identifier read, reset command, secondary bank ignoring it
      unl(4'h7); wr(16'h7555, 8'h90); run(1'b1, 16'h0001, 1'b0);
      chk("ident", 16'(ID), 16'(doneData));
      wr(16'h0000, 8'hf0); run(1'b1, 16'h0001, 1'b0);
      chk("array after reset", 16'h3d, 16'(doneData));
      unl(4'h0); wr(16'h0555, 8'h90); run(1'b1, 16'h0001, 1'b1);
      chk("secondary ident", 16'h3d, 16'(doneData));
      wr(16'h0000, 8'hf0); run(1'b0, 16'h0, 1'b1);
      for (i = 0; i < 2; i++) begin
         @(negedge clk) sectProtected = i[0];
         unl(4'h0); wr(16'h0555, 8'h90); run(1'b1, 16'h0002, 1'b0);
         chk("protect status", 16'(i[0]), 16'(doneData));
         wr(16'h0000, 8'hf0); run(1'b0, 16'h0, 1'b0);
      end
      // Sector erase, one queued sector, then a late one after the window closed
      @(negedge clk) eraseBusy = 1'b1;
      unl(4'h0); wr(16'h0555, 8'h80); unl(4'h0); wr(16'h3000, 8'h30); run(1'b0, 16'h0, 1'b0);
      ex(1, fcd_pkg::FCD_OP_SECT, 1'b0, 16'h3000);
      wr(16'h5000, 8'h30); run(1'b0, 16'h0, 1'b0);
      ex(1, fcd_pkg::FCD_OP_SECT, 1'b0, 16'h5000);
      repeat (150) @(posedge clk);
      wr(16'h6000, 8'h30); run(1'b0, 16'h0, 1'b0);
      ex(0, fcd_pkg::FCD_OP_NONE, 1'b0, 16'h0);
      wr(16'h0124, 8'hb0); run(1'b0, 16'h0, 1'b0);
      ex(1, fcd_pkg::FCD_OP_SUSP, 1'b0, 16'h0);
      wr(16'h0456, 8'h30); run(1'b0, 16'h0, 1'b0);
      ex(1, fcd_pkg::FCD_OP_RESUME, 1'b0, 16'h0);
      @(negedge clk) eraseBusy = 1'b0;
      wr(16'h0124, 8'hb0); run(1'b0, 16'h0, 1'b0);
      ex(0, fcd_pkg::FCD_OP_NONE, 1'b0, 16'h0);
      unl(4'h0); wr(16'h0555, 8'h80); unl(4'h0); wr(16'h0555, 8'h10); run(1'b0, 16'h0, 1'b1);
      ex(1, fcd_pkg::FCD_OP_BULK, 1'b1, 16'h0);
      // Bypass: two-write programs, exit, then a bare program is refused
      unl(4'h0); wr(16'h0555, 8'h20); run(1'b0, 16'h0, 1'b0);
      for (i = 0; i < 3; i++) begin
         r = $random(seed);
         wr({r[31:17], 1'b0}, 8'ha0); wr(r[15:0], r[23:16]); run(1'b0, 16'h0, 1'b0);
         ex(1, fcd_pkg::FCD_OP_PROG, 1'b0, r[15:0]);
         chk("bypass data", 16'(r[23:16]), 16'(opData));
      end
      wr(16'h0000, 8'h90); wr(16'h0010, 8'h00); run(1'b1, 16'h0044, 1'b0);
      chk("array after bypass", 16'h78, 16'(doneData));
      wr(16'h0000, 8'ha0); wr(16'h1000, 8'h77); run(1'b0, 16'h0, 1'b0);
      ex(0, fcd_pkg::FCD_OP_NONE, 1'b0, 16'h0);
      // Gap between command bytes: too long aborts, short enough completes
      unl(4'h0); run(1'b0, 16'h0, 1'b0);
      repeat (80) @(posedge clk);
      wr(16'h0555, 8'ha0); wr(16'h2000, 8'h11); run(1'b0, 16'h0, 1'b0);
      ex(0, fcd_pkg::FCD_OP_NONE, 1'b0, 16'h0);
      unl(4'h0); run(1'b0, 16'h0, 1'b0);
      wr(16'h0555, 8'ha0); wr(16'h2000, 8'h11); run(1'b0, 16'h0, 1'b0);
      ex(1, fcd_pkg::FCD_OP_PROG, 1'b0, 16'h2000);
      // Error flag holds through other commands until the reset command
      @(negedge clk) opFail = 1'b1;
      @(negedge clk) opFail = 1'b0;
      repeat (3) @(posedge clk);
      chk("error set", 16'h1, 16'(errorFlag));
      unl(4'h0); wr(16'h0555, 8'ha0); wr(16'h2002, 8'h22); run(1'b0, 16'h0, 1'b0);
      chk("error held", 16'h1, 16'(errorFlag));
      wr(16'h0000, 8'hf0); run(1'b0, 16'h0, 1'b0);
      chk("error cleared", 16'h0, 16'(errorFlag));
      close_out();
   end
endmodule
